/* File: logic/sar_pkg.sv */
// Package with constants and types for the setpoint alarm relay control block
package sar_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_RELAYS = 2;
  localparam int NUM_SP     = 4;
  localparam int SET_W      = 7;

  // ----------------------------------------------------------------
  // Limits and scaling
  // ----------------------------------------------------------------
  localparam logic [SET_W-1:0] MAX_DELAY_S = 7'h63;
  localparam logic [SET_W-1:0] MAX_HYST    = 7'h63;
  localparam logic [SET_W-1:0] PCT_FULL    = 7'h64;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ        = 100_000_000;
  localparam longint TICK_PERIOD_S = 1;
  localparam int     TICK_CYCLES   = int'(CLK_HZ * TICK_PERIOD_S);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic              RST_ENABLE = 1'b0;
  localparam logic [NUM_SP-1:0] RST_MASK   = 4'h0;
  localparam logic [SET_W-1:0]  RST_DELAY  = 7'h00;
  localparam logic [SET_W-1:0]  RST_HYST   = 7'h00;
  localparam logic              RST_INVERT = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAR_SP_OFF  = 2'h0,
    SAR_SP_HIGH = 2'h1,
    SAR_SP_LOW  = 2'h2
  } sar_sp_type_t;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_ARMING,
    SAR_ACTIVE
  } sar_relay_state_t;

endpackage

/* File: logic/sar_tick_gen.sv */
// One-second tick generator for the relay delay counters
module sar_tick_gen
  import sar_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  output logic      tick
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } sar_tick_st_t;

  sar_tick_st_t st_r;
  sar_tick_st_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= 32'(CYCLES - 1)) begin
      st_nxt.cnt  = 32'h0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule

/* File: logic/sar_relay_ctrl.sv */
// Two alarm relays driven from four setpoint error conditions
// ----------------------------------------------------------------
// Functional notes
// - Two relays are provided, each programmable independently and each able to use any of the four setpoints.
// - Each relay holds a four-bit setpoint mask and requests activation when any masked setpoint is in error.
// - An active relay stays active until every assigned setpoint has left its error condition.
// - A per-relay invert bit flips the coil drive so the open and closed contacts swap roles.
// - The invert bit returns to normal on reset, so power loss restores the normal contact state.
// - A relay activates on the delay-th free-running seconds tick after its request rises, so up to one second early; a dropped request restarts it.
// - The delay setting takes whole seconds from 0 to 99; larger writes saturate at 99.
// - Release needs the measurement to move back past the setpoint by the relay's hysteresis percentage.
// - The hysteresis setting takes whole percent values from 0 to 99; larger writes saturate at 99.
// - A disabled relay never activates whatever its other settings are.
// - A setpoint errs above a high limit or below a low limit, and an off setpoint errs only through its over-range option.
// - With its over-range option set, a measurement over-range counts as that setpoint in error.
// ----------------------------------------------------------------
module sar_relay_ctrl
  import sar_pkg::*;
#(
  parameter int MEAS_W      = 16,
  parameter int TICK_CYCLES = sar_pkg::TICK_CYCLES
) (
  input  wire logic                               ref_clk,
  input  wire logic                               reset,
  input  wire logic [NUM_SP-1:0][MEAS_W-1:0]      spMeasure,
  input  wire logic [NUM_SP-1:0][MEAS_W-1:0]      spLimit,
  input  wire logic [NUM_SP-1:0][1:0]             spType,
  input  wire logic [NUM_SP-1:0]                  spOverRangeOpt,
  input  wire logic [NUM_SP-1:0]                  spOverRange,
  input  wire logic                               cfgWrite,
  input  wire logic                               cfgRelaySel,
  input  wire logic                               cfgEnable,
  input  wire logic [NUM_SP-1:0]                  cfgMask,
  input  wire logic [SET_W-1:0]                   cfgDelay,
  input  wire logic [SET_W-1:0]                   cfgHyst,
  input  wire logic                               cfgInvert,
  output logic      [NUM_RELAYS-1:0]              relayCoil,
  output logic      [NUM_RELAYS-1:0]              relayActive,
  output logic      [NUM_RELAYS-1:0][NUM_SP-1:0]  relayErrors
);

  localparam int PROD_W = MEAS_W + 8;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             enable;
    logic [NUM_SP-1:0] mask;
    logic [SET_W-1:0] delay;
    logic [SET_W-1:0] hyst;
    logic             invert;
    logic [NUM_SP-1:0] errLatch;
    logic [SET_W-1:0] secCnt;
    sar_relay_state_t state;
    logic             coil;
    logic             active;
  } sar_relay_t;

  typedef struct packed {
    sar_relay_t [NUM_RELAYS-1:0] rel;
  } sar_st_t;

  sar_st_t st_r;
  sar_st_t st_nxt;
  logic    secTick;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [SET_W-1:0] clamp99(input logic [SET_W-1:0] v, input logic [SET_W-1:0] lim);
    clamp99 = (v > lim) ? lim : v;
  endfunction

  function automatic logic rawError(input logic [1:0] t, input logic [MEAS_W-1:0] m,
                                    input logic [MEAS_W-1:0] lim);
    logic r;
    r = 1'b0;
    if (t == SAR_SP_HIGH) begin
      r = (m > lim);
    end else if (t == SAR_SP_LOW) begin
      r = (m < lim);
    end
    rawError = r;
  endfunction

  function automatic logic hystClear(input logic [1:0] t, input logic [MEAS_W-1:0] m,
                                     input logic [MEAS_W-1:0] lim, input logic [SET_W-1:0] h);
    logic [PROD_W-1:0] mScaled;
    logic [PROD_W-1:0] bound;
    logic              c;
    mScaled = PROD_W'(m) * PROD_W'(PCT_FULL);
    bound   = '0;
    c       = 1'b0;
    if (t == SAR_SP_HIGH) begin
      bound = PROD_W'(lim) * PROD_W'(PCT_FULL - h);
      c     = (mScaled < bound);
    end else if (t == SAR_SP_LOW) begin
      bound = PROD_W'(lim) * (PROD_W'(PCT_FULL) + PROD_W'(h));
      c     = (mScaled > bound);
    end
    hystClear = c;
  endfunction

  // ----------------------------------------------------------------
  // Seconds tick
  // ----------------------------------------------------------------
  sar_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .reset   (reset),
    .tick    (secTick)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [NUM_SP-1:0] errEff;
    logic              req;
    errEff = '0;
    req    = 1'b0;
    st_nxt = st_r;
    for (int r = 0; r < NUM_RELAYS; r++) begin
      // Configuration load
      if (cfgWrite && (cfgRelaySel == 1'(r))) begin
        st_nxt.rel[r].enable = cfgEnable;
        st_nxt.rel[r].mask   = cfgMask;
        st_nxt.rel[r].delay  = clamp99(cfgDelay, MAX_DELAY_S);
        st_nxt.rel[r].hyst   = clamp99(cfgHyst, MAX_HYST);
        st_nxt.rel[r].invert = cfgInvert;
      end

      // Per-setpoint error latches with this relay's hysteresis
      for (int s = 0; s < NUM_SP; s++) begin
        if (!st_r.rel[r].enable || spType[s] == SAR_SP_OFF) begin
          st_nxt.rel[r].errLatch[s] = 1'b0;
        end else if (rawError(spType[s], spMeasure[s], spLimit[s])) begin
          st_nxt.rel[r].errLatch[s] = 1'b1;
        end else if (hystClear(spType[s], spMeasure[s], spLimit[s], st_r.rel[r].hyst)) begin
          st_nxt.rel[r].errLatch[s] = 1'b0;
        end
      end
      errEff = st_nxt.rel[r].errLatch | (spOverRangeOpt & spOverRange);
      req    = |(st_r.rel[r].mask & errEff);

      // Activation sequencing
      if (!st_r.rel[r].enable) begin
        st_nxt.rel[r].state  = SAR_IDLE;
        st_nxt.rel[r].secCnt = '0;
      end else begin
        unique case (st_r.rel[r].state)
          SAR_IDLE: begin
            st_nxt.rel[r].secCnt = '0;
            if (req) begin
              if (st_r.rel[r].delay == RST_DELAY) begin
                st_nxt.rel[r].state = SAR_ACTIVE;
              end else begin
                st_nxt.rel[r].state = SAR_ARMING;
              end
            end
          end
          SAR_ARMING: begin
            if (!req) begin
              st_nxt.rel[r].state  = SAR_IDLE;
              st_nxt.rel[r].secCnt = '0;
            end else if (secTick) begin
              st_nxt.rel[r].secCnt = st_r.rel[r].secCnt + SET_W'(1);
              if (st_r.rel[r].secCnt + SET_W'(1) >= st_r.rel[r].delay) begin
                st_nxt.rel[r].state = SAR_ACTIVE;
              end
            end
          end
          SAR_ACTIVE: begin
            if (!req) begin
              st_nxt.rel[r].state  = SAR_IDLE;
              st_nxt.rel[r].secCnt = '0;
            end
          end
          default: begin
            st_nxt.rel[r].state  = SAR_IDLE;
            st_nxt.rel[r].secCnt = '0;
          end
        endcase
      end

      // Contact drive
      st_nxt.rel[r].active = (st_nxt.rel[r].state == SAR_ACTIVE);
      st_nxt.rel[r].coil   = st_nxt.rel[r].active ^ st_nxt.rel[r].invert;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int r = 0; r < NUM_RELAYS; r++) begin
        st_r.rel[r].enable   <= RST_ENABLE;
        st_r.rel[r].mask     <= RST_MASK;
        st_r.rel[r].delay    <= RST_DELAY;
        st_r.rel[r].hyst     <= RST_HYST;
        st_r.rel[r].invert   <= RST_INVERT;
        st_r.rel[r].errLatch <= '0;
        st_r.rel[r].secCnt   <= '0;
        st_r.rel[r].state    <= SAR_IDLE;
        st_r.rel[r].coil     <= 1'b0;
        st_r.rel[r].active   <= 1'b0;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int r = 0; r < NUM_RELAYS; r++) begin
      relayCoil[r]   = st_r.rel[r].coil;
      relayActive[r] = st_r.rel[r].active;
      relayErrors[r] = st_r.rel[r].errLatch;
    end
  end

endmodule

/* File: tb/sar_chk_assertions.sv */
// Port checker for the relay control block
module sar_chk
  import sar_pkg::*;
#(
  parameter int MEAS_W = 16
) (
  input wire logic                              ref_clk,
  input wire logic                              reset,
  input wire logic [NUM_SP-1:0][MEAS_W-1:0]     spMeasure,
  input wire logic [NUM_SP-1:0][MEAS_W-1:0]     spLimit,
  input wire logic [NUM_SP-1:0][1:0]            spType,
  input wire logic [NUM_SP-1:0]                 spOverRangeOpt,
  input wire logic [NUM_SP-1:0]                 spOverRange,
  input wire logic                              cfgWrite,
  input wire logic [NUM_RELAYS-1:0]             relayCoil,
  input wire logic [NUM_RELAYS-1:0]             relayActive,
  input wire logic [NUM_RELAYS-1:0][NUM_SP-1:0] relayErrors
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic ovr;
  logic cw;
  assign ovr = |(spOverRangeOpt & spOverRange);
  assign cw = cfgWrite;
  property p_rst; disable iff (1'h0) reset |=> relayActive == 2'h0 && relayCoil == 2'h0 && relayErrors == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_set; $rose(relayErrors[0][0]) |-> $past(spType[0] == 2'h1 && spMeasure[0] > spLimit[0]
    || spType[0] == 2'h2 && spMeasure[0] < spLimit[0]); endproperty
  a_set: assert property (p_set) else $error("error latch set without limit crossing");
  property p_off; spType[0] == 2'h0 |=> relayErrors[0][0] == 1'h0 && relayErrors[1][0] == 1'h0; endproperty
  a_off: assert property (p_off) else $error("off setpoint reports error");
  property p_act0; relayActive[0] |-> |relayErrors[0] || $past(ovr) || $past(cw, 2); endproperty
  a_act0: assert property (p_act0) else $error("relay 0 active with no error");
  property p_act1; relayActive[1] |-> |relayErrors[1] || $past(ovr) || $past(cw, 2); endproperty
  a_act1: assert property (p_act1) else $error("relay 1 active with no error");
  property p_coil; $changed(relayCoil) |-> $changed(relayActive) || $past(cw) || $past(cw, 2); endproperty
  a_coil: assert property (p_coil) else $error("coil changed without cause");
  property p_clrh; $fell(relayErrors[0][0]) && $past(spType[0]) == 2'h1
    |-> $past(spMeasure[0] < spLimit[0]) || $past(cw) || $past(cw, 2); endproperty
  a_clrh: assert property (p_clrh) else $error("high error cleared above limit");
  property p_clrl; $fell(relayErrors[1][1]) && $past(spType[1]) == 2'h2
    |-> $past(spMeasure[1] > spLimit[1]) || $past(cw) || $past(cw, 2); endproperty
  a_clrl: assert property (p_clrl) else $error("low error cleared below limit");
  c_act0: cover property ($rose(relayActive[0]));
  c_act1: cover property ($rose(relayActive[1]));
  c_clr: cover property ($fell(relayErrors[0][0]));
endmodule

bind sar_relay_ctrl sar_chk #(.MEAS_W(MEAS_W)) u_chk (.ref_clk, .reset, .spMeasure, .spLimit, .spType,
  .spOverRangeOpt, .spOverRange, .cfgWrite, .relayCoil, .relayActive, .relayErrors);

/* File: tb/sar_contact_load.sv */
// Contact model of the equipment wired to the two relays
module sar_contact_load
  import sar_pkg::*;
(
  input  wire logic [NUM_RELAYS-1:0] relayCoil,
  output logic      [NUM_RELAYS-1:0] noClosed,
  output logic      [NUM_RELAYS-1:0] ncClosed
);
  timeunit 1ns;
  timeprecision 100ps;
  // Energised coil closes the open contact and opens the closed one
  assign noClosed = relayCoil;
  assign ncClosed = ~relayCoil;
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the relay control block
module tb
  import sar_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed { logic [15:0] m; logic [1:0] t; logic [3:0] f; } sar_row_t;
  logic                              ref_clk = 1'h0;
  logic                              reset = 1'h1;
  logic [NUM_SP-1:0][15:0]           spMeasure = '0;
  logic [NUM_SP-1:0][15:0]           spLimit = '0;
  logic [NUM_SP-1:0][1:0]            spType = '0;
  logic [NUM_SP-1:0]                 spOverRangeOpt = '0;
  logic [NUM_SP-1:0]                 spOverRange = '0;
  logic                              cfgWrite = 1'h0, cfgRelaySel = 1'h0, cfgEnable = 1'h0, cfgInvert = 1'h0;
  logic [NUM_SP-1:0]                 cfgMask = '0;
  logic [SET_W-1:0]                  cfgDelay = '0, cfgHyst = '0;
  logic [NUM_RELAYS-1:0]             relayCoil, relayActive, noClosed, ncClosed;
  logic [NUM_RELAYS-1:0][NUM_SP-1:0] relayErrors;
  int                                nFail = 0, cmpCount = 0, cycCount = 0;
  // Measure, type, {option, over-range, active, error}
  sar_row_t rows [8] = '{'{16'h0032, 2'h1, 4'h0}, '{16'h0096, 2'h1, 4'h3}, '{16'h0032, 2'h2, 4'h3},
    '{16'h0096, 2'h2, 4'h0}, '{16'h0096, 2'h0, 4'h0}, '{16'h0032, 2'h0, 4'he}, '{16'h0032, 2'h0, 4'h4},
    '{16'h0064, 2'h1, 4'h0}};

  sar_relay_ctrl #(.MEAS_W(16), .TICK_CYCLES(10)) DUT (.ref_clk, .reset, .spMeasure, .spLimit, .spType,
    .spOverRangeOpt, .spOverRange, .cfgWrite, .cfgRelaySel, .cfgEnable, .cfgMask, .cfgDelay, .cfgHyst,
    .cfgInvert, .relayCoil, .relayActive, .relayErrors);
  sar_contact_load u_load (.relayCoil, .noClosed, .ncClosed);

  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic giveVerdict();
    if (nFail == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      nFail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cfg(input logic r, en, input logic [3:0] m, input logic [6:0] d, h, input logic inv);
    {cfgRelaySel, cfgEnable, cfgMask, cfgDelay, cfgHyst, cfgInvert} = {r, en, m, d, h, inv};
    cfgWrite = 1'h1;
    cyc(1);
    cfgWrite = 1'h0;
    cyc(1);
  endtask
  task automatic st(input int r, input logic [15:0] m, input logic e);
    spMeasure[r] = m;
    cyc(1);
    chk("active", {7'h0, e}, {7'h0, relayActive[r]});
  endtask

  always @(posedge ref_clk) begin
    cycCount++;
    if (cycCount == 3000) begin
      nFail++;
      giveVerdict();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    reset = 1'h0;
    {spType[0], spLimit[0], spMeasure[0]} = {2'h1, 16'h0064, 16'h0096};
    cyc(2);
    chk("dflt", 8'h00, {4'h0, relayActive, relayCoil});
    chk("errs", 8'h00, relayErrors);
    cfg(1'h0, 1'h1, 4'h1, 7'h00, 7'h00, 1'h0);
    foreach (rows[i]) begin
      spMeasure[0] = rows[i].m;
      spType[0] = rows[i].t;
      {spOverRangeOpt[0], spOverRange[0]} = rows[i].f[3:2];
      cyc(1);
      chk("row act", {7'h0, rows[i].f[1]}, {7'h0, relayActive[0]});
      chk("row err", {7'h0, rows[i].f[0]}, {7'h0, relayErrors[0][0]});
    end
    cfg(1'h1, 1'h1, 4'h0, 7'h00, 7'h00, 1'h1);
    chk("coil", 8'h02, {6'h0, relayCoil});
    chk("nc", 8'h01, {6'h0, ncClosed});
    chk("no", 8'h02, {6'h0, noClosed});
    reset = 1'h1;
    cyc(2);
    reset = 1'h0;
    spMeasure[0] = 16'h0096;
    cyc(2);
    chk("rst", 8'h00, {4'h0, relayActive, relayCoil});
    cfg(1'h0, 1'h1, 4'h1, 7'h00, 7'h0a, 1'h0);
    st(0, 16'h0096, 1'h1);
    st(0, 16'h005f, 1'h1);
    st(0, 16'h0059, 1'h0);
    {spType[1], spLimit[1], spMeasure[1]} = {2'h2, 16'h0064, 16'h0064};
    cfg(1'h1, 1'h1, 4'h2, 7'h00, 7'h0a, 1'h0);
    st(1, 16'h0032, 1'h1);
    st(1, 16'h0069, 1'h1);
    st(1, 16'h006f, 1'h0);
    cfg(1'h0, 1'h1, 4'h1, 7'h00, 7'h7f, 1'h0);
    st(0, 16'h0096, 1'h1);
    st(0, 16'h0001, 1'h1);
    st(0, 16'h0000, 1'h0);
    spType[1] = 2'h1;
    spMeasure[1] = 16'h0096;
    cfg(1'h0, 1'h1, 4'h3, 7'h00, 7'h00, 1'h0);
    st(0, 16'h0096, 1'h1);
    st(0, 16'h0032, 1'h1);
    st(1, 16'h0032, 1'h0);
    chk("multi", 8'h00, {7'h0, relayActive[0]});
    cfg(1'h0, 1'h1, 4'h1, 7'h03, 7'h00, 1'h0);
    spMeasure[0] = 16'h0096;
    cyc(15);
    st(0, 16'h0032, 1'h0);
    spMeasure[0] = 16'h0096;
    cyc(19);
    chk("restart", 8'h00, {7'h0, relayActive[0]});
    cyc(12);
    chk("delay", 8'h01, {7'h0, relayActive[0]});
    st(0, 16'h0032, 1'h0);
    cfg(1'h0, 1'h1, 4'h1, 7'h7f, 7'h00, 1'h0);
    spMeasure[0] = 16'h0096;
    cyc(980);
    chk("sat lo", 8'h00, {7'h0, relayActive[0]});
    cyc(12);
    chk("sat hi", 8'h01, {7'h0, relayActive[0]});
    cfg(1'h0, 1'h0, 4'h1, 7'h00, 7'h00, 1'h0);
    chk("dis act", 8'h00, {7'h0, relayActive[0]});
    chk("dis err", 8'h00, {7'h0, relayErrors[0][0]});
    giveVerdict();
  end
endmodule
